// *** rtl/scanner_regs.vh ***
`ifndef SCANNER_REGS_VH
`define SCANNER_REGS_VH
`define COLS 4'h8
`define CUR_BASE 8'h20
`define PREV_BASE 8'h28
`define FIRST_COL 8'h80
`define COL_ALL_OFF 8'h00
`define LAST_IDX 3'h7
`define VAR_ONEHOT 2'h0
`define VAR_BUFFER 2'h1
`define VAR_MUX 2'h2
`define SETTLE_RESET 8'h04
`define SETTLE_DONE 8'h00
`define WAIT_STEP 8'h01
`define IDX_STEP 3'h1
`define CODE_RESET 3'h0
`define BYTE_CLEAR 8'h00
`define MAP_CLEAR 64'h0
`endif

// *** rtl/map_store.v ***
`timescale 1ns/1ps
`default_nettype none
`include "scanner_regs.vh"
module map_store (
   input wire clk,
   input wire rst,
   input wire we,
   input wire [2:0] wr_col,
   input wire [7:0] wr_data,
   input wire [7:0] rd_addr,
   output reg [7:0] rd_data,
   output wire [63:0] cur_flat,
   output wire [63:0] prev_flat
);
   reg [7:0] cur_q [0:7];
   reg [7:0] prev_q [0:7];
   genvar i;
   ////////////////////////////////////////////////////////////////////////
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_col
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               cur_q[i] <= 8'h00;
               prev_q[i] <= 8'h00;
            end else if (we && wr_col == i) begin
               prev_q[i] <= cur_q[i];
               cur_q[i] <= wr_data;
            end
         end
         assign cur_flat[8*i+7:8*i] = cur_q[i];
         assign prev_flat[8*i+7:8*i] = prev_q[i];
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   // Byte view, current at one base, previous at the next
   always @* begin
      rd_data = 8'h00;
      if (rd_addr >= `CUR_BASE && rd_addr < `PREV_BASE) begin
         rd_data = cur_q[rd_addr[2:0]];
      end else if (rd_addr >= `PREV_BASE &&
                   rd_addr < `PREV_BASE + {4'h0, `COLS}) begin
         rd_data = prev_q[rd_addr[2:0]];
      end
   end
endmodule
`default_nettype wire

// *** rtl/sensor_matrix_scanner.v ***
`timescale 1ns/1ps
`default_nettype none
`include "scanner_regs.vh"
module sensor_matrix_scanner (
   input wire clk,
   input wire rst,
   input wire start,
   input wire [1:0] variant,
   input wire [7:0] settle_cycles,
   input wire [7:0] row_return_port,
   input wire [7:0] map_addr,
   output reg [7:0] column_select_port,
   output reg [2:0] column_code_q,
   output reg row_bus_free_q,
   output reg busy_q,
   output reg done_q,
   output reg [7:0] map_byte_q,
   output reg [63:0] current_map_q,
   output reg [63:0] previous_map_q,
   output reg [63:0] changed_q
);
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_SETTLE = 2'h1;
   localparam [1:0] S_SAMPLE = 2'h2;

   reg [1:0] state_q;
   reg [7:0] mask_q;
   reg [2:0] idx_q;
   reg [7:0] wait_q;
   reg we;
   wire [7:0] rd_data;
   wire [63:0] cur_flat;
   wire [63:0] prev_flat;

   // Next values; each control pin below is the flop of one of these, the map pins are not
   reg [1:0] state_d;
   reg [7:0] mask_d;
   reg [2:0] idx_d;
   reg [7:0] wait_d;
   reg [7:0] select_d;
   reg [2:0] code_d;
   reg bus_free_d;
   reg busy_d;
   reg done_d;
   reg [7:0] drive_d;
   reg [7:0] shaped_d;

   map_store u_maps (
      .clk(clk),
      .rst(rst),
      .we(we),
      .wr_col(idx_q),
      .wr_data(row_return_port),
      .rd_addr(map_addr),
      .rd_data(rd_data),
      .cur_flat(cur_flat),
      .prev_flat(prev_flat)
   );

   ////////////////////////////////////////////////////////////////////////
   // Rows read high for closure, stored as is
   always @* begin
      we = (state_q == S_SAMPLE);
   end

   // Idle drive and column drive shaped per variant
   always @* begin
      drive_d = `COL_ALL_OFF;
      shaped_d = mask_q;
      if (variant == `VAR_BUFFER) begin
         drive_d = ~`COL_ALL_OFF;
         shaped_d = ~mask_q;
      end else if (variant == `VAR_MUX) begin
         // Mux variant leaves the lines low; the code selects
         shaped_d = `COL_ALL_OFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Scan sequencing: column position, settle count, state
   always @* begin
      state_d = state_q;
      mask_d = mask_q;
      idx_d = idx_q;
      wait_d = wait_q;

      case (state_q)
         S_IDLE: begin
            // Start only seen in idle, so a busy pass ignores it
            if (start) begin
               mask_d = `FIRST_COL;
               idx_d = `LAST_IDX;
               wait_d = settle_cycles;
               state_d = S_SETTLE;
            end
         end

         S_SETTLE: begin
            // Zero settle still gives one cycle of drive
            if (wait_q == `SETTLE_DONE) begin
               state_d = S_SAMPLE;
            end else begin
               wait_d = wait_q - `WAIT_STEP;
            end
         end

         S_SAMPLE: begin
            mask_d = {mask_q[0], mask_q[7:1]};
            idx_d = idx_q - `IDX_STEP;
            wait_d = settle_cycles;
            if (mask_q[0]) begin
               state_d = S_IDLE;
            end else begin
               state_d = S_SETTLE;
            end
         end

         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin values for the coming cycle
   always @* begin
      select_d = column_select_port;
      code_d = column_code_q;
      bus_free_d = row_bus_free_q;
      busy_d = busy_q;
      done_d = 1'b0;

      case (state_q)
         S_IDLE: begin
            select_d = drive_d;
            bus_free_d = 1'b1;
            if (start) begin
               busy_d = 1'b1;
            end
         end

         S_SETTLE: begin
            // Rows see the drive settle_cycles plus one edges
            bus_free_d = 1'b0;
            code_d = idx_q;
            select_d = shaped_d;
         end

         S_SAMPLE: begin
            if (mask_q[0]) begin
               busy_d = 1'b0;
               done_d = 1'b1;
               select_d = drive_d;
               bus_free_d = 1'b1;
            end
         end

         default: begin
            done_d = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset value is constant: in the buffer variant every enable
   // reads low until the first idle edge after reset
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         mask_q <= `FIRST_COL;
         idx_q <= `LAST_IDX;
         wait_q <= `SETTLE_DONE;
         column_select_port <= `COL_ALL_OFF;
         column_code_q <= `CODE_RESET;
         row_bus_free_q <= 1'b1;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mask_q <= mask_d;
         idx_q <= idx_d;
         wait_q <= wait_d;
         column_select_port <= select_d;
         column_code_q <= code_d;
         row_bus_free_q <= bus_free_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered copies; lag maps by one cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         map_byte_q <= `BYTE_CLEAR;
         current_map_q <= `MAP_CLEAR;
         previous_map_q <= `MAP_CLEAR;
         changed_q <= `MAP_CLEAR;
      end else begin
         map_byte_q <= rd_data;
         current_map_q <= cur_flat;
         previous_map_q <= prev_flat;
         changed_q <= cur_flat ^ prev_flat;
      end
   end
endmodule
`default_nettype wire

// *** test/scanner_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module scanner_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] variant,
   input wire logic [7:0] column_select_port,
   input wire logic [2:0] column_code_q,
   input wire logic row_bus_free_q,
   input wire logic busy_q,
   input wire logic done_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Busy rises one edge before the first column is driven
   sequence s_step;
      busy_q && $past(busy_q) && $past(busy_q, 2) &&
         $changed(column_select_port);
   endsequence
   a_onehot_drive: assert property (
      variant == 2'h0 && busy_q && $past(busy_q)
      |-> $onehot(column_select_port))
      else $error("drive not one-hot");
   a_low_enable: assert property (
      variant == 2'h1 && busy_q && $past(busy_q)
      |-> $onehot(~column_select_port))
      else $error("enable not active-low");
   a_first_col: assert property (
      $rose(busy_q) && variant == 2'h0
      |=> column_select_port == 8'h80)
      else $error("first column wrong");
   a_col_rotate: assert property (
      ((variant == 2'h0) and s_step)
      |-> column_select_port == ($past(column_select_port) >> 1))
      else $error("no rotate");
   a_mux_first: assert property (
      $rose(busy_q) |=> column_code_q == 3'h7)
      else $error("code not 7");
   a_bus_held: assert property (
      busy_q && $past(busy_q) |-> !row_bus_free_q)
      else $error("bus free mid scan");
   a_done_pulse: assert property (
      done_q |=> !done_q)
      else $error("done too long");
   a_done_idle: assert property (
      done_q |-> !busy_q && row_bus_free_q)
      else $error("done while busy");
endmodule
`default_nettype wire

// *** test/sensor_matrix_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sensor_matrix_model (
   input wire logic [1:0] variant,
   input wire logic [7:0] column_select_port,
   input wire logic [2:0] column_code_q,
   input wire logic [63:0] pattern,
   output logic [7:0] row_return_port
);
   logic [7:0] en;
   always_comb begin
      en = (variant == 2'h1) ? ~column_select_port : column_select_port;
      // Pull-downs read zero when no column conducts
      row_return_port = 8'h00;
      if (variant == 2'h2) begin
         row_return_port = pattern[column_code_q*8 +: 8];
      end else if ($onehot(en)) begin
         for (int c = 0; c < 8; c++) begin
            if (en[c]) row_return_port = pattern[c*8 +: 8];
         end
      end
   end
endmodule
`default_nettype wire

// *** test/tb_sensor_matrix_scanner.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_matrix_scanner;
   localparam logic [63:0] P1 = 64'h0123_4567_89ab_cdef;
   localparam logic [63:0] P2 = 64'hfedc_ba98_7654_3210;
   localparam logic [63:0] P3 = 64'h8001_ff00_5aa5_c33c;
   logic clk = 0, rst = 1, start = 0;
   logic [1:0] variant = 0;
   logic [7:0] settle_cycles = 0, map_addr = 8'h20;
   logic [63:0] pattern = 0;
   wire logic [7:0] row_return_port, column_select_port, map_byte_q;
   wire logic [2:0] column_code_q;
   wire logic row_bus_free_q, busy_q, done_q;
   wire logic [63:0] current_map_q, previous_map_q, changed_q;
   int n_fail = 0, samples_checked = 0;
   sensor_matrix_scanner dut (.clk, .rst, .start, .variant, .settle_cycles,
      .row_return_port, .map_addr, .column_select_port, .column_code_q,
      .row_bus_free_q, .busy_q, .done_q, .map_byte_q, .current_map_q,
      .previous_map_q, .changed_q);
   sensor_matrix_model mdl (.variant, .column_select_port, .column_code_q,
      .pattern, .row_return_port);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Start held one edge only, so a held start cannot rescan
   task automatic scan(input logic [1:0] v, input logic [7:0] s,
                       input logic [63:0] p);
      int i;
      variant = v;
      settle_cycles = s;
      pattern = p;
      start = 1;
      @(negedge clk);
      start = 0;
      for (i = 0; i < 400 && done_q !== 1'b1; i++) @(negedge clk);
      if (i == 400) begin
         n_fail++;
         conclude();
      end
      repeat (2) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      check({56'h0, column_select_port}, 64'h0);
      check(current_map_q, 64'h0);
      check(previous_map_q, 64'h0);
   endtask
   task automatic t_onehot;
      scan(2'h0, 8'h00, P1);
      check(current_map_q, P1);
      check(previous_map_q, 64'h0);
   endtask
   task automatic t_buffer;
      scan(2'h1, 8'h03, P2);
      check(current_map_q, P2);
      check(previous_map_q, P1);
   endtask
   task automatic t_mux;
      scan(2'h2, 8'h01, P3);
      check(current_map_q, P3);
      check(changed_q, P2 ^ P3);
      for (int c = 0; c < 8; c++) begin
         map_addr = 8'h20 + c[7:0];
         @(negedge clk);
         check({56'h0, map_byte_q}, {56'h0, P3[c*8 +: 8]});
         map_addr = 8'h28 + c[7:0];
         @(negedge clk);
         check({56'h0, map_byte_q}, {56'h0, P2[c*8 +: 8]});
      end
      map_addr = 8'h30;
      @(negedge clk);
      check({56'h0, map_byte_q}, 64'h0);
   endtask
   initial forever #20 clk = ~clk;
   initial begin
      repeat (8) @(negedge clk);
      t_reset();
      rst = 0;
      @(negedge clk);
      t_onehot();
      t_buffer();
      t_mux();
      conclude();
   end
endmodule
bind sensor_matrix_scanner scanner_sva chk (.clk, .rst, .variant,
   .column_select_port, .column_code_q, .row_bus_free_q, .busy_q, .done_q);
`default_nettype wire
